// ### hdl/apsr_regs.svh
// Purpose: Register indices, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes: Definitions only
`ifndef APSR_REGS_SVH
`define APSR_REGS_SVH

// ****************************************
// Bus address and register indices
// ****************************************
`define APSR_I2C_ADDR 7'h6c
`define APSR_IDX_STATUS 8'h02
`define APSR_IDX_PARAM 8'h03

// ****************************************
// Field layout
// ****************************************
`define APSR_OL_BIT 2
`define APSR_GS_BIT 1
`define APSR_GAIN_MSB 7
`define APSR_GAIN_LSB 6
`define APSR_PL_MSB 5
`define APSR_PL_LSB 3
`define APSR_RSVD_BIT 2
`define APSR_FREQ_MSB 1
`define APSR_FREQ_LSB 0
`define APSR_PARAM_RESET 8'h3a
`define APSR_PARAM_WMASK 8'hfb
`define APSR_STATUS_RESET 8'h00
`define APSR_UNMAPPED_READ 8'h00

// ****************************************
// Byte framing
// ****************************************
`define APSR_BIT_FIRST 4'h0
`define APSR_BIT_LAST 4'h7
`define APSR_ACK_SLOT 4'h8

// ****************************************
// Timing
// ****************************************
`define APSR_CLK_MHZ 100
`define APSR_SOFT_START_US 100
`define APSR_SOFT_START_CYCLES (`APSR_SOFT_START_US * `APSR_CLK_MHZ)
`define APSR_SS_CNT_W 14

`endif

// ### hdl/apsr_pkg.sv
// Purpose: Shared types of the amplifier register bank
// Assumes: Nothing
// Notes: Constants live in apsr_regs.svh
package apsr_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_INDEX = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_IGNORE = 3'b101
	} apsr_state_t;

endpackage : apsr_pkg

// ### hdl/apsr_soft_start.sv
// Purpose: Soft-start ramp timer for the power stage
// Assumes: stageOn comes from logic on the same clock
// Notes: Ramp is cancelled whenever the stage stops switching
`timescale 1ns/10ps
`include "apsr_regs.svh"

module apsr_soft_start #(
	parameter int CYCLES = `APSR_SOFT_START_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic stageOn,
	output logic rampBusy,
	output logic rampDone
);

	logic stagePrev;
	logic [`APSR_SS_CNT_W-1:0] count;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stagePrev <= 1'b0;
		end else begin
			stagePrev <= stageOn;
		end
	end

	// ****************************************
	// Ramp counter
	// ****************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rampBusy <= 1'b0;
			rampDone <= 1'b0;
			count <= '0;
		end else if (!stageOn) begin
			rampBusy <= 1'b0;
			rampDone <= 1'b0;
			count <= '0;
		end else if (!stagePrev) begin
			rampBusy <= 1'b1; // RULE6
			rampDone <= 1'b0;
			count <= '0;
		end else if (rampBusy) begin
			if (count == `APSR_SS_CNT_W'(CYCLES - 1)) begin
				rampBusy <= 1'b0; // RULE7
				rampDone <= 1'b1;
			end else begin
				count <= count + 1'b1;
			end
		end
	end

	chk_ramp_start: assert property (@(posedge clock) disable iff (!nrst) // RULE6
		$rose(stageOn) |=> rampBusy && !rampDone && count == '0)
		else $error("Ramp did not start with the power stage");

	chk_ramp_end: assert property (@(posedge clock) disable iff (!nrst) // RULE7
		rampBusy && stageOn && count == `APSR_SS_CNT_W'(CYCLES - 1) |=> rampDone && !rampBusy)
		else $error("Ramp did not end at its cycle count");

endmodule : apsr_soft_start

// ### hdl/apsr_param_status_regs.sv
// Purpose: Parameter and load-status registers reached over an I2C slave port
// Assumes: Pins are asynchronous to clock; SCL well below clock/8
// Notes: Only the status and parameter registers are mapped here
`timescale 1ns/10ps
`include "apsr_regs.svh"

// What the document asks of this block and its controller
// RULE1 - Open-load flag follows open-load presence
// RULE2 - Ground-short flag follows ground-short presence
// RULE3 - Gain field bits 7:6, resets 00
// RULE4 - Power-limit field bits 5:3, resets 111
// RULE5 - Frequency field bits 1:0, resets 10
// RULE6 - Soft start whenever power stage starts switching
// RULE7 - Soft start lasts about 100 microseconds
// RULE8 - Controller waits 100 us before input signal
// RULE9 - Load detection held in play near zero
// RULE10 - Controller runs diagnostics before replaying
// RULE11 - Shutdown steps need no waiting
// RULE12 - Answer I2C address 0x6c, 0xd8/0xd9
// RULE13 - Write: address, index, data, each acknowledged
// RULE14 - Reserved bit 2 ignores writes, reads zero
module apsr_param_status_regs
	import apsr_pkg::*;
#(
	parameter int SOFT_START_CYCLES = `APSR_SOFT_START_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	input wire logic openLoadIn,
	input wire logic groundShortIn,
	input wire logic playModeIn,
	input wire logic signalNearZeroIn,
	input wire logic muteIn,
	input wire logic overloadIn,
	input wire logic overTempIn,
	output logic open_load_flag,
	output logic ground_short_flag,
	output logic [1:0] gainSelect,
	output logic [2:0] power_limit_select,
	output logic [1:0] freqSelect,
	output logic powerStageOn,
	output logic softStartBusy,
	output logic softStartDone
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int NPINS = 9;
	logic [NPINS-1:0] pinMeta;
	logic [NPINS-1:0] pinSync;
	logic [NPINS-1:0] pinRaw;
	logic sclS, sdaS, olS, gsS, playS, zeroS, muteS, ovlS, otS;
	logic sclD, sdaD;

	assign pinRaw = {sclIn, sdaIn, openLoadIn, groundShortIn, playModeIn,
		signalNearZeroIn, muteIn, overloadIn, overTempIn};
	assign {sclS, sdaS, olS, gsS, playS, zeroS, muteS, ovlS, otS} = pinSync;

	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_sync
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					pinMeta[gi] <= 1'b1;
					pinSync[gi] <= 1'b1;
				end else begin
					pinMeta[gi] <= pinRaw[gi];
					pinSync[gi] <= pinMeta[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sclD <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclD <= sclS;
			sdaD <= sdaS;
		end
	end

	logic sclRise, sclFall, startCond, stopCond;
	assign sclRise = sclS && !sclD;
	assign sclFall = !sclS && sclD;
	assign startCond = sclS && sclD && sdaD && !sdaS;
	assign stopCond = sclS && sclD && !sdaD && sdaS;

	// ****************************************
	// Load status flags
	// ****************************************
	// Near-zero play switches both halves together, so detection would lie
	logic holdDiag;
	assign holdDiag = playS && zeroS;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			open_load_flag <= 1'b0;
			ground_short_flag <= 1'b0;
		end else if (!holdDiag) begin // RULE9
			open_load_flag <= olS; // RULE1
			ground_short_flag <= gsS; // RULE2
		end
	end

	logic [7:0] statusByte;
	always_comb begin
		statusByte = `APSR_STATUS_RESET;
		statusByte[`APSR_OL_BIT] = open_load_flag;
		statusByte[`APSR_GS_BIT] = ground_short_flag;
	end

	// ****************************************
	// Parameter register
	// ****************************************
	logic [7:0] paramReg;
	logic wrStrobe;
	logic [7:0] wrData;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			paramReg <= `APSR_PARAM_RESET; // RULE3 RULE4 RULE5
		end else if (wrStrobe) begin
			paramReg <= wrData & `APSR_PARAM_WMASK; // RULE14
		end
	end

	assign gainSelect = paramReg[`APSR_GAIN_MSB:`APSR_GAIN_LSB]; // RULE3
	assign power_limit_select = paramReg[`APSR_PL_MSB:`APSR_PL_LSB]; // RULE4
	assign freqSelect = paramReg[`APSR_FREQ_MSB:`APSR_FREQ_LSB]; // RULE5

	function automatic logic [7:0] readMux(input logic [7:0] idx, input logic [7:0] stat,
		input logic [7:0] par);
		if (idx == `APSR_IDX_STATUS) begin
			return stat;
		end else if (idx == `APSR_IDX_PARAM) begin
			return par;
		end else begin
			return `APSR_UNMAPPED_READ;
		end
	endfunction : readMux

	// ****************************************
	// I2C protocol engine
	// ****************************************
	apsr_state_t state;
	logic [3:0] bitCnt;
	logic [7:0] shiftReg;
	logic [7:0] regIndex;
	logic [7:0] txByte;
	logic ackPend;
	logic rdSent;
	logic [7:0] rxByte;
	assign rxByte = {shiftReg[6:0], sdaS};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			bitCnt <= `APSR_BIT_FIRST;
			shiftReg <= '0;
			regIndex <= '0;
			txByte <= '0;
			ackPend <= 1'b0;
			rdSent <= 1'b0;
			wrStrobe <= 1'b0;
			wrData <= '0;
		end else begin
			wrStrobe <= 1'b0;
			if (startCond) begin
				state <= ST_ADDR;
				bitCnt <= `APSR_BIT_FIRST;
				ackPend <= 1'b0;
				rdSent <= 1'b0;
			end else if (stopCond) begin
				state <= ST_IDLE;
				bitCnt <= `APSR_BIT_FIRST;
				ackPend <= 1'b0;
				rdSent <= 1'b0;
			end else if (sclRise && state != ST_IDLE) begin
				if (bitCnt == `APSR_ACK_SLOT) begin
					bitCnt <= `APSR_BIT_FIRST;
					ackPend <= 1'b0;
					if (state == ST_RDATA && rdSent) begin
						rdSent <= 1'b0;
						if (sdaS) begin
							state <= ST_IGNORE;
						end else begin
							regIndex <= regIndex + 1'b1;
							txByte <= readMux(regIndex + 1'b1, statusByte, paramReg);
						end
					end
				end else begin
					shiftReg <= rxByte;
					bitCnt <= bitCnt + 1'b1;
					if (bitCnt == `APSR_BIT_LAST) begin
						case (state)
							ST_ADDR: begin
								if (rxByte[7:1] == `APSR_I2C_ADDR) begin // RULE12
									ackPend <= 1'b1; // RULE13
									state <= rxByte[0] ? ST_RDATA : ST_INDEX;
									txByte <= readMux(regIndex, statusByte, paramReg);
								end else begin
									state <= ST_IGNORE;
								end
							end
							ST_INDEX: begin
								regIndex <= rxByte;
								ackPend <= 1'b1; // RULE13
								state <= ST_WDATA;
							end
							ST_WDATA: begin
								wrStrobe <= (regIndex == `APSR_IDX_PARAM);
								wrData <= rxByte;
								regIndex <= regIndex + 1'b1;
								ackPend <= 1'b1; // RULE13
							end
							ST_RDATA: begin
								rdSent <= 1'b1;
							end
							default: begin
							end
						endcase
					end
				end
			end
		end
	end

	// ****************************************
	// SDA driver
	// ****************************************
	// Changes only after SCL falls, apart from a release on a start or stop, so the master never sees a false start
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sdaOeN <= 1'b1;
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
			if (startCond || stopCond) begin
				sdaOeN <= 1'b1;
			end else if (sclFall) begin
				if (bitCnt == `APSR_ACK_SLOT) begin
					sdaOeN <= !ackPend; // RULE13
				end else if (state == ST_RDATA) begin
					sdaOeN <= txByte[3'(`APSR_BIT_LAST - bitCnt)];
				end else begin
					sdaOeN <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Power stage and soft start
	// ****************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			powerStageOn <= 1'b0;
		end else begin
			powerStageOn <= !muteS && !ovlS && !otS; // RULE6
		end
	end

	apsr_soft_start #(
		.CYCLES(SOFT_START_CYCLES)
	) u_soft_start (
		.clock(clock),
		.nrst(nrst),
		.stageOn(powerStageOn),
		.rampBusy(softStartBusy),
		.rampDone(softStartDone)
	);

	// ****************************************
	// Checks
	// ****************************************
	// Flag takes the synced level of the same cycle, so one step is all it may lag
	chk_ol_follow: assert property (@(posedge clock) disable iff (!nrst) // RULE1
		!holdDiag && olS |=> open_load_flag)
		else $error("Open-load flag missed a present open load");

	chk_gs_follow: assert property (@(posedge clock) disable iff (!nrst) // RULE2
		!holdDiag && !gsS |=> !ground_short_flag)
		else $error("Ground-short flag set without a short");

	chk_diag_hold: assert property (@(posedge clock) disable iff (!nrst) // RULE9
		holdDiag |=> $stable(open_load_flag) && $stable(ground_short_flag))
		else $error("Load flags changed in quiet play");

	chk_gain_write: assert property (@(posedge clock) disable iff (!nrst) // RULE3
		wrStrobe |=> gainSelect == $past(wrData[7:6]) && freqSelect == $past(wrData[1:0]))
		else $error("Gain or frequency field not written");

	chk_pl_write: assert property (@(posedge clock) disable iff (!nrst) // RULE4
		wrStrobe |=> power_limit_select == $past(wrData[5:3]))
		else $error("Power-limit field not written");

	chk_rsvd_zero: assert property (@(posedge clock) disable iff (!nrst) // RULE14
		!paramReg[`APSR_RSVD_BIT])
		else $error("Reserved parameter bit is set");

	chk_addr_ack: assert property (@(posedge clock) disable iff (!nrst) // RULE12
		sclRise && state == ST_ADDR && bitCnt == `APSR_BIT_LAST &&
		rxByte[7:1] == `APSR_I2C_ADDR |-> ##[1:1000] !sdaOeN)
		else $error("Own address not acknowledged");

	chk_other_quiet: assert property (@(posedge clock) disable iff (!nrst) // RULE12
		state == ST_IGNORE && $past(state) == ST_IGNORE |-> sdaOeN)
		else $error("Drove SDA for another address");

	chk_mute_ramp: assert property (@(posedge clock) disable iff (!nrst) // RULE6
		$fell(muteS) && !ovlS && !otS |-> ##[1:3] softStartBusy)
		else $error("No soft start after mute release");

endmodule : apsr_param_status_regs

// ### testbench/apsr_i2c_master.sv
// Purpose: Bus master model that reaches the register bank
// Assumes: SDA pulled up; this model alone drives SCL
// Notes: Each data-bit SCL phase lasts 10 clocks, above the 8-clock minimum
`timescale 1ns/10ps
`include "apsr_regs.svh"

module apsr_i2c_master (
	input wire logic clock,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaLow
);
	// ********************
	// Bus cycles
	// ********************
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic hold();
		repeat (10) @(negedge clock);
	endtask : hold
	task automatic start();
		sdaLow = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sdaLow = 1'b1;
		hold();
		scl = 1'b0;
	endtask : start
	task automatic stop();
		repeat (3) @(negedge clock);
		sdaLow = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sdaLow = 1'b0;
		hold();
	endtask : stop
	// SDA moves 3 clocks after SCL falls, so no false start or stop is seen
	task automatic xfer(input logic b, output logic s);
		repeat (3) @(negedge clock);
		sdaLow = !b;
		repeat (7) @(negedge clock);
		scl = 1'b1;
		hold();
		s = sdaLine;
		scl = 1'b0;
	endtask : xfer
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer(d[i], s);
		end
		xfer(1'b1, s);
		ack = !s;
	endtask : sendByte
	task automatic recvByte(input logic ackIt, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, d[i]);
		end
		xfer(!ackIt, s);
	endtask : recvByte
	task automatic writeReg(input logic [6:0] adr, input logic [7:0] idx,
		input logic [7:0] data, output logic ok);
		logic a0, a1, a2;
		start();
		sendByte({adr, 1'b0}, a0);
		sendByte(idx, a1);
		sendByte(data, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : writeReg
	task automatic readReg(input logic [7:0] idx, output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		sendByte({`APSR_I2C_ADDR, 1'b0}, a0);
		sendByte(idx, a1);
		start();
		sendByte({`APSR_I2C_ADDR, 1'b1}, a2);
		recvByte(1'b0, d);
		stop();
		ok = a0 & a1 & a2;
	endtask : readReg
endmodule : apsr_i2c_master

// ### testbench/tb_amp_param_status_regs.sv
// Purpose: Self-checking bench of the amplifier register bank
// Assumes: Soft start shortened to 20 clocks
// Notes: Inputs change on falling clock edges
`timescale 1ns/10ps
`include "apsr_regs.svh"

module tb_amp_param_status_regs;
	// ********************
	// Harness
	// ********************
	localparam int SS = 20;
	logic clock = 1'b0, nrst = 1'b0, scl, sdaLow, sdaOeN, sdaOut, sdaLine;
	logic ol = 1'b0, gs = 1'b0, play = 1'b0, nz = 1'b0, mute = 1'b1, ovl = 1'b0, ot = 1'b0;
	logic olFlag, gsFlag, stageOn, busy, done, ok;
	logic [1:0] gain, freq;
	logic [2:0] pl;
	logic [7:0] rd;
	int failures = 0, comparisons = 0, cycles = 0;
	always #5 clock = ~clock;
	assign sdaLine = ~(sdaLow | ~sdaOeN);
	apsr_i2c_master apsr_i2c_master_inst (.clock(clock), .sdaLine(sdaLine), .scl(scl),
		.sdaLow(sdaLow));
	apsr_param_status_regs #(.SOFT_START_CYCLES(SS)) apsr_param_status_regs_inst (
		.clock(clock), .nrst(nrst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOeN(sdaOeN), .openLoadIn(ol), .groundShortIn(gs), .playModeIn(play),
		.signalNearZeroIn(nz), .muteIn(mute), .overloadIn(ovl), .overTempIn(ot),
		.open_load_flag(olFlag), .ground_short_flag(gsFlag), .gainSelect(gain),
		.power_limit_select(pl), .freqSelect(freq), .powerStageOn(stageOn),
		.softStartBusy(busy), .softStartDone(done));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// Ceiling is several times the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			failures++;
			stop_test();
		end
	end
	// ********************
	// Scenarios
	// ********************
	task automatic test_params();
		logic [7:0] d;
		apsr_i2c_master_inst.readReg(`APSR_IDX_PARAM, rd, ok);
		check(rd, 8'h3a, "param reset");
		check({gain, pl, freq}, {2'b00, 3'b111, 2'b10}, "fields reset");
		check(sdaOut, 1'b0, "open drain level");
		for (int c = 0; c < 4; c++) begin
			d = {c[1:0], 1'b0, c[1:0], 1'b1, c[1:0]};
			apsr_i2c_master_inst.writeReg(`APSR_I2C_ADDR, `APSR_IDX_PARAM, d, ok);
			check(ok, 1'b1, "write acks");
			check({gain, pl, freq}, {c[1:0], 1'b0, c[1:0], c[1:0]}, "fields");
			apsr_i2c_master_inst.readReg(`APSR_IDX_PARAM, rd, ok);
			check(rd, d & 8'hfb, "param readback");
		end
		apsr_i2c_master_inst.writeReg(7'h6d, `APSR_IDX_PARAM, 8'h00, ok);
		check(ok, 1'b0, "foreign address acked");
		check(gain, 2'h3, "foreign write took effect");
		apsr_i2c_master_inst.readReg(8'h05, rd, ok);
		check(rd, 8'h00, "unmapped read");
		$display("test_params done");
	endtask : test_params
	task automatic test_status();
		@(negedge clock);
		ol = 1'b1;
		repeat (6) @(negedge clock);
		check(olFlag, 1'b1, "open load");
		apsr_i2c_master_inst.readReg(`APSR_IDX_STATUS, rd, ok);
		check(rd, 8'h04, "status open load");
		ol = 1'b0;
		gs = 1'b1;
		repeat (6) @(negedge clock);
		apsr_i2c_master_inst.readReg(`APSR_IDX_STATUS, rd, ok);
		check(rd, 8'h02, "status ground short");
		play = 1'b1;
		nz = 1'b1;
		repeat (6) @(negedge clock);
		ol = 1'b1;
		gs = 1'b0;
		repeat (10) @(negedge clock);
		check({olFlag, gsFlag}, 2'b01, "flags held near zero");
		nz = 1'b0;
		repeat (6) @(negedge clock);
		check({olFlag, gsFlag}, 2'b10, "flags after hold");
		{ol, play} = 2'b00;
		repeat (6) @(negedge clock);
		check(olFlag, 1'b0, "open load gone");
		$display("test_status done");
	endtask : test_status
	task automatic test_soft_start();
		int n;
		for (int c = 0; c < 3; c++) begin
			@(negedge clock);
			{ot, ovl, mute} = 3'(1 << c);
			repeat (10) @(negedge clock);
			check({stageOn, busy, done}, 3'b000, "stage stopped");
			{ot, ovl, mute} = 3'b000;
			n = 0;
			while (!busy && n < 10) begin
				@(negedge clock);
				n++;
			end
			n = 0;
			while (busy === 1'b1 && n < 100) begin
				@(negedge clock);
				n++;
			end
			check(8'(n), 8'(SS), "ramp length");
			check({stageOn, done}, 2'b11, "ramp finished");
			// Input signal only after the ramp
			repeat (SS) @(negedge clock);
		end
		$display("test_soft_start done");
	endtask : test_soft_start
	initial begin
		repeat (16) @(negedge clock);
		nrst = 1'b1;
		repeat (10) @(negedge clock);
		test_params();
		test_status();
		test_soft_start();
		stop_test();
	end
endmodule : tb_amp_param_status_regs
